//--- verilog/pfp_pkg.sv
// Constants and types for the front panel knob and button control
package pfp_pkg;
    localparam int NCH = 3;
    localparam int NBTN = 6;
    // Button indices
    localparam int BTN_RES = 0;
    localparam int BTN_ZERO = 1;
    localparam int BTN_MAX = 2;
    localparam int BTN_LOOP = 3;
    localparam int BTN_UNIT = 4;
    localparam int BTN_CHAN = 5;
    // Resolution states, coarse is the power-up value
    typedef enum logic [1:0] {
        RES_COARSE = 2'b00,
        RES_FINE = 2'b01,
        RES_PARK = 2'b10
    } pfp_res_t;
    // Limit selections, setpoint LSB is 10 mV
    localparam logic [1:0] LIM_SEL_75 = 2'h0;
    localparam logic [1:0] LIM_SEL_100 = 2'h1;
    localparam logic [1:0] LIM_SEL_150 = 2'h2;
    localparam logic [1:0] LIM_SEL_RST = LIM_SEL_75;
    localparam logic [15:0] LIM_75 = 16'h1D4C;
    localparam logic [15:0] LIM_100 = 16'h2710;
    localparam logic [15:0] LIM_150 = 16'h3A98;
    // Knob scaling: 75 V span over about 12 coarse turns
    localparam int ENC_CPR = 20;
    localparam int SPAN_TURNS = 12;
    localparam int COARSE_RATIO = 10;
    localparam logic [15:0] FINE_STEP =
        16'(int'(LIM_75) / (SPAN_TURNS * ENC_CPR * COARSE_RATIO));
    localparam logic [15:0] COARSE_STEP = 16'(int'(FINE_STEP) * COARSE_RATIO);
    localparam logic [15:0] ZERO_DEC = 16'h0004;
    localparam logic [3:0] BRIGHT_RST = 4'h8;
    // Timing
    localparam int CLK_KHZ = 100000;
    localparam int MS_CYC_DEF = CLK_KHZ;
    localparam int DEB_MS = 5;
    localparam int BLINK_MS = 250;
    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SETPT = 8'h08;
    localparam logic [7:0] REG_BRIGHT = 8'h0C;
    localparam int CTRL_IDENT = 0;
    localparam int CTRL_ZERO = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- verilog/pfp_panel.sv
// Front panel control: buttons, knob, lamps, display and register slave
// Operation
// - Resolution release cycles coarse, fine, parked
// - Coarse step is ten times fine
// - Coarse 75 V span about twelve turns
// - Parked state ignores knob rotation
// - Resolution resets to coarse
// - Zeroed lamp flashes while zeroing
// - Zeroing display counts down toward zero
// - Zeroed lamp steady after zeroing
// - Max release enters flashing limit edit
// - Knob cycles limit 75, 100, 150
// - Second max release stores limit
// - Legacy stage forces 75 V limit
// - Clockwise saturates at limit, reverses immediately
// - Anticlockwise saturates at zero, reverses immediately
// - Closed adjusts position, open adjusts voltage
// - Loop button toggles; closed lamp follows
// - Unit button toggles microns or volts
// - Held resolution button: knob sets brightness
// - Host identify makes display flash
// - Panel actions apply to selected channel
`timescale 1ns/1ps
module pfp_panel #(
    parameter int MS_CYC = pfp_pkg::MS_CYC_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [pfp_pkg::NBTN-1:0] btn,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic legacy_stage,
    input wire logic [pfp_pkg::NCH-1:0] zero_done,
    output logic [15:0] disp_value,
    output logic disp_blank,
    output logic [3:0] disp_bright,
    output logic lamp_microns,
    output logic lamp_closed,
    output logic lamp_zeroed,
    output logic [pfp_pkg::NCH-1:0] chan_led,
    output logic [pfp_pkg::NCH-1:0][15:0] volt_sp,
    output logic [pfp_pkg::NCH-1:0][15:0] pos_sp,
    output logic [pfp_pkg::NCH-1:0] loop_closed,
    output logic [pfp_pkg::NCH-1:0] zeroing
);
    localparam int NCH = pfp_pkg::NCH;

    typedef struct packed {
        logic [19:0] pre;
        logic [7:0] bl;
        logic ph;
        logic [pfp_pkg::NBTN-1:0] stab;
        logic [pfp_pkg::NBTN-1:0][2:0] dcnt;
        logic qa;
        logic [1:0] sel;
        logic edit;
        logic [1:0] cand;
        logic hturn;
        logic [3:0] bright;
        logic [NCH-1:0][1:0] res;
        logic [NCH-1:0] closed;
        logic [NCH-1:0] microns;
        logic [NCH-1:0] zing;
        logic [NCH-1:0] zed;
        logic [NCH-1:0][1:0] lim;
        logic [1:0][NCH-1:0][15:0] sp;
        logic [NCH-1:0][15:0] zc;
        logic ident;
        logic awg;
        logic wg;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [15:0] dval;
        logic dblank;
        logic lm;
        logic lc;
        logic lz;
    } pfp_st_t;

    pfp_st_t s;
    pfp_st_t next_s;
    logic tick;
    logic cw;
    logic ccw;
    logic knob;
    logic zreq;
    logic [pfp_pkg::NBTN-1:0] pr;
    logic [pfp_pkg::NBTN-1:0] rl;
    logic [15:0] step;
    logic [15:0] elim;
    logic [16:0] sum;
    logic msel;

    function automatic logic [15:0] lim_v(input logic [1:0] l);
        case (l)
            pfp_pkg::LIM_SEL_100: lim_v = pfp_pkg::LIM_100;
            pfp_pkg::LIM_SEL_150: lim_v = pfp_pkg::LIM_150;
            default: lim_v = pfp_pkg::LIM_75;
        endcase
    endfunction

    function automatic logic [1:0] cyc3(input logic [1:0] v, input logic up);
        if (up) begin
            cyc3 = (v == 2'h2) ? 2'h0 : v + 2'h1;
        end else begin
            cyc3 = (v == 2'h0) ? 2'h2 : v - 2'h1;
        end
    endfunction

    always_comb begin
        next_s = s;
        zreq = 1'b0;
        elim = pfp_pkg::LIM_75;
        sum = '0;
        // Millisecond prescaler shared by debounce, blink and zeroing
        tick = (s.pre == 20'(MS_CYC - 1));
        next_s.pre = tick ? '0 : s.pre + 20'h1;
        if (tick) begin
            next_s.bl = s.bl + 8'h1;
            if (s.bl == 8'(pfp_pkg::BLINK_MS - 1)) begin
                next_s.bl = '0;
                next_s.ph = ~s.ph;
            end
        end
        // A level must hold for DEB_MS ticks before it counts
        for (int i = 0; i < pfp_pkg::NBTN; i++) begin
            if (btn[i] == s.stab[i]) begin
                next_s.dcnt[i] = '0;
            end else if (tick) begin
                if (s.dcnt[i] == 3'(pfp_pkg::DEB_MS - 1)) begin
                    next_s.stab[i] = btn[i];
                    next_s.dcnt[i] = '0;
                end else begin
                    next_s.dcnt[i] = s.dcnt[i] + 3'h1;
                end
            end
        end
        pr = next_s.stab & ~s.stab;
        rl = s.stab & ~next_s.stab;
        // One count per rising edge of A, B gives direction
        next_s.qa = enc_a;
        cw = enc_a & ~s.qa & ~enc_b;
        ccw = enc_a & ~s.qa & enc_b;
        knob = cw | ccw;
        step = (s.res[s.sel] == pfp_pkg::RES_FINE) ?
            pfp_pkg::FINE_STEP : pfp_pkg::COARSE_STEP;
        msel = s.closed[s.sel];
        if (pr[pfp_pkg::BTN_CHAN]) begin
            next_s.sel = (s.sel == 2'(NCH - 1)) ? 2'h0 : s.sel + 2'h1;
        end
        if (rl[pfp_pkg::BTN_MAX]) begin
            if (s.edit) begin
                next_s.lim[s.sel] = s.cand;
                next_s.edit = 1'b0;
            end else begin
                next_s.edit = 1'b1;
                next_s.cand = s.lim[s.sel];
            end
        end
        if (pr[pfp_pkg::BTN_RES]) begin
            next_s.hturn = 1'b0;
        end
        if (s.stab[pfp_pkg::BTN_RES]) begin
            if (knob) begin
                next_s.hturn = 1'b1;
                if (cw && s.bright != 4'hF) begin
                    next_s.bright = s.bright + 4'h1;
                end else if (ccw && s.bright != 4'h0) begin
                    next_s.bright = s.bright - 4'h1;
                end
            end
        end else if (s.edit) begin
            if (knob) begin
                next_s.cand = cyc3(s.cand, cw);
            end
        end else if (knob && s.res[s.sel] != pfp_pkg::RES_PARK) begin
            elim = legacy_stage ? pfp_pkg::LIM_75 : lim_v(s.lim[s.sel]);
            if (cw) begin
                sum = {1'b0, s.sp[msel][s.sel]} + {1'b0, step};
                next_s.sp[msel][s.sel] =
                    (sum > {1'b0, elim}) ? elim : sum[15:0];
            end else begin
                next_s.sp[msel][s.sel] = (s.sp[msel][s.sel] > step) ?
                    s.sp[msel][s.sel] - step : 16'h0000;
            end
        end
        // Release toggles only if the knob was not used for brightness,
        // a turn in the release cycle itself counts as used
        if (rl[pfp_pkg::BTN_RES] && !next_s.hturn) begin
            case (s.res[s.sel])
                pfp_pkg::RES_COARSE: next_s.res[s.sel] = pfp_pkg::RES_FINE;
                pfp_pkg::RES_FINE: next_s.res[s.sel] = pfp_pkg::RES_PARK;
                default: next_s.res[s.sel] = pfp_pkg::RES_COARSE;
            endcase
        end
        if (pr[pfp_pkg::BTN_LOOP]) begin
            next_s.closed[s.sel] = ~s.closed[s.sel];
        end
        if (pr[pfp_pkg::BTN_UNIT]) begin
            next_s.microns[s.sel] = ~s.microns[s.sel];
        end
        // Register slave, address and data may come in either order
        if (awvalid && !s.awg && !s.bv) begin
            next_s.awg = 1'b1;
            next_s.awa = awaddr;
        end
        if (wvalid && !s.wg && !s.bv) begin
            next_s.wg = 1'b1;
            next_s.wd = wdata;
            next_s.ws = wstrb;
        end
        if (s.awg && s.wg) begin
            next_s.awg = 1'b0;
            next_s.wg = 1'b0;
            next_s.bv = 1'b1;
            next_s.br = pfp_pkg::RESP_DECERR;
            if (s.awa == pfp_pkg::REG_CTRL) begin
                next_s.br = pfp_pkg::RESP_OKAY;
                if (s.ws[0]) begin
                    next_s.ident = s.wd[pfp_pkg::CTRL_IDENT];
                    zreq = s.wd[pfp_pkg::CTRL_ZERO];
                end
            end
        end
        if (s.bv && bready) begin
            next_s.bv = 1'b0;
        end
        if (arvalid && !s.rv) begin
            next_s.rv = 1'b1;
            next_s.rr = pfp_pkg::RESP_OKAY;
            case (araddr)
                pfp_pkg::REG_CTRL: next_s.rd = {31'h0, s.ident};
                pfp_pkg::REG_STAT: next_s.rd = {20'h0, legacy_stage, s.zed[s.sel],
                    s.zing[s.sel], s.microns[s.sel], s.closed[s.sel], s.edit,
                    s.res[s.sel], 2'h0, s.sel};
                pfp_pkg::REG_SETPT: next_s.rd = {16'h0, s.sp[msel][s.sel]};
                pfp_pkg::REG_BRIGHT: next_s.rd = {28'h0, s.bright};
                default: begin
                    next_s.rd = '0;
                    next_s.rr = pfp_pkg::RESP_DECERR;
                end
            endcase
        end else if (s.rv && rready) begin
            next_s.rv = 1'b0;
        end
        // Zeroing display walks down until the loop reports done or the count reaches zero
        for (int c = 0; c < NCH; c++) begin
            if (s.zing[c]) begin
                if (zero_done[c] || s.zc[c] == 16'h0000) begin
                    next_s.zing[c] = 1'b0;
                    next_s.zed[c] = 1'b1;
                end else if (tick) begin
                    next_s.zc[c] = (s.zc[c] > pfp_pkg::ZERO_DEC) ?
                        s.zc[c] - pfp_pkg::ZERO_DEC : 16'h0000;
                end
            end
        end
        if (pr[pfp_pkg::BTN_ZERO] || zreq) begin
            next_s.zing[s.sel] = 1'b1;
            next_s.zed[s.sel] = 1'b0;
            next_s.zc[s.sel] = s.sp[1][s.sel];
        end
        // A lowered limit pulls setpoints down, so reversal is immediate
        for (int c = 0; c < NCH; c++) begin
            for (int j = 0; j < 2; j++) begin
                if (legacy_stage && next_s.sp[j][c] > pfp_pkg::LIM_75) begin
                    next_s.sp[j][c] = pfp_pkg::LIM_75;
                end else if (next_s.sp[j][c] > lim_v(next_s.lim[c])) begin
                    next_s.sp[j][c] = lim_v(next_s.lim[c]);
                end
            end
        end
        if (next_s.edit) begin
            next_s.dval = lim_v(next_s.cand);
        end else if (next_s.zing[next_s.sel]) begin
            next_s.dval = next_s.zc[next_s.sel];
        end else begin
            next_s.dval = next_s.sp[next_s.microns[next_s.sel]][next_s.sel];
        end
        next_s.dblank = (next_s.edit | next_s.ident) & next_s.ph;
        next_s.lm = next_s.microns[next_s.sel];
        next_s.lc = next_s.closed[next_s.sel];
        next_s.lz = next_s.zing[next_s.sel] ? next_s.ph : next_s.zed[next_s.sel];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.bright <= pfp_pkg::BRIGHT_RST;
            s.lim <= {NCH{pfp_pkg::LIM_SEL_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign awready = !s.awg && !s.bv;
    assign wready = !s.wg && !s.bv;
    assign bvalid = s.bv;
    assign bresp = s.br;
    assign arready = !s.rv;
    assign rvalid = s.rv;
    assign rdata = s.rd;
    assign rresp = s.rr;
    assign disp_value = s.dval;
    assign disp_blank = s.dblank;
    assign disp_bright = s.bright;
    assign lamp_microns = s.lm;
    assign lamp_closed = s.lc;
    assign lamp_zeroed = s.lz;
    assign volt_sp = s.sp[0];
    assign pos_sp = s.sp[1];
    assign loop_closed = s.closed;
    assign zeroing = s.zing;
    assign chan_led = NCH'(1) << s.sel;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_step(logic [1:0] r, logic [15:0] st);
        s.sel == 2'h0 && !s.stab[0] && !s.edit && !s.closed[0] && s.res[0] == r
            && cw && !legacy_stage && s.sp[0][0] < 16'h0100
        |=> s.sp[0][0] == $past(s.sp[0][0]) + st;
    endproperty

    chk_coarse_step: assert property (p_step(pfp_pkg::RES_COARSE, 16'h001E))
        else $error("coarse step wrong");
    chk_fine_step: assert property (p_step(pfp_pkg::RES_FINE, 16'h0003))
        else $error("fine step wrong");
    chk_park_hold: assert property (s.res[0] == pfp_pkg::RES_PARK && !s.edit
        && !legacy_stage |=> $stable(s.sp[0][0]))
        else $error("parked setpoint moved");
    chk_res_reset: assert property (disable iff (1'b0) !aresetn |=> s.res == '0)
        else $error("resolution not coarse after reset");
    chk_sp_limit: assert property (s.sp[0][0] <= lim_v(s.lim[0]))
        else $error("setpoint above limit");
    chk_legacy_cap: assert property (legacy_stage |=> s.sp[1][0] <= pfp_pkg::LIM_75)
        else $error("legacy limit not applied");
    chk_ccw_floor: assert property (s.sel == 2'h0 && !s.stab[0] && !s.edit
        && s.res[0] != pfp_pkg::RES_PARK
        && !s.closed[0] && ccw && s.sp[0][0] <= 16'h0003 |=> s.sp[0][0] == 16'h0000)
        else $error("setpoint not floored");
    chk_zero_flash: assert property (s.zing[s.sel] |-> lamp_zeroed == s.ph)
        else $error("zeroed lamp not flashing");
    chk_zero_done: assert property ($fell(s.zing[0]) |-> s.zed[0] ##1 s.zed[0])
        else $error("zeroed lamp not lit after zeroing");
    chk_bright_hold: assert property (s.stab[0] && knob |=> $stable(s.res))
        else $error("resolution changed while held");
    chk_closed_lamp: assert property (pr[pfp_pkg::BTN_LOOP] && !pr[pfp_pkg::BTN_CHAN]
        |=> ##1 lamp_closed == !$past(s.closed[s.sel], 2))
        else $error("closed lamp does not follow mode");
    chk_write_resp: assert property (s.awg && s.wg |=> bvalid)
        else $error("write not answered");

    cov_edit_store: cover property (s.edit ##[1:20] !s.edit);
    cov_zero_run: cover property (s.zing[0] ##[1:50] s.zed[0]);
    cov_ident: cover property (s.ident && disp_blank);
    cov_park: cover property (s.res[0] == pfp_pkg::RES_PARK && cw);
endmodule

//--- verification/pfp_operator.sv
// Operator model: presses panel buttons and turns the endless knob
`timescale 1ns/1ps
module pfp_operator (
    input wire logic aclk,
    output logic [pfp_pkg::NBTN-1:0] btn,
    output logic enc_a,
    output logic enc_b
);
    initial begin
        btn = '0;
        enc_a = 1'b0;
        enc_b = 1'b0;
    end
    // Sets one button level, then waits out the debounce
    task automatic hold_level(input int idx, input logic lvl);
        @(posedge aclk);
        btn[idx] <= lvl;
        repeat (40) @(posedge aclk);
        #1;
    endtask
    // Short holds model contact bounce and must be ignored
    task automatic press(input int idx, input int hold);
        @(posedge aclk);
        btn[idx] <= 1'b1;
        repeat (hold) @(posedge aclk);
        btn[idx] <= 1'b0;
        repeat (40) @(posedge aclk);
        #1;
    endtask
    // Direction set ahead of the A rise so it is never sampled mid-change
    task automatic turn(input logic cw, input int n);
        repeat (n) begin
            @(posedge aclk);
            enc_b <= !cw;
            repeat (2) @(posedge aclk);
            enc_a <= 1'b1;
            repeat (3) @(posedge aclk);
            enc_a <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        #1;
    endtask
endmodule

//--- verification/tb.sv
// Self-checking testbench for the front panel control block
`timescale 1ns/1ps
module tb;
    logic aclk;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [pfp_pkg::NBTN-1:0] btn;
    logic enc_a, enc_b;
    logic legacy_stage = 1'b0;
    logic [pfp_pkg::NCH-1:0] zero_done = '0;
    logic [15:0] disp_value;
    logic disp_blank, lamp_microns, lamp_closed, lamp_zeroed;
    logic [3:0] disp_bright;
    logic [pfp_pkg::NCH-1:0] chan_led, loop_closed, zeroing;
    logic [pfp_pkg::NCH-1:0][15:0] volt_sp, pos_sp;
    int err_count = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [15:0] keep;

    // Debounce shortened to 20 cycles, blink half period to 1000
    pfp_panel #(.MS_CYC(4)) i_pfp_panel (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .btn, .enc_a, .enc_b, .legacy_stage, .zero_done, .disp_value, .disp_blank,
        .disp_bright, .lamp_microns, .lamp_closed, .lamp_zeroed, .chan_led, .volt_sp,
        .pos_sp, .loop_closed, .zeroing
    );
    pfp_operator i_pfp_operator (.aclk, .btn, .enc_a, .enc_b);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic timeout();
        err_count++;
        $display("MISMATCH wait expected answer seen none");
        stop_test();
    endtask
    task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask
    task automatic stat_res(input logic [1:0] e);
        axi_rd(pfp_pkg::REG_STAT, rd, rs);
        check_val("stat_res", 32'(e), 32'(rd[5:4]));
    endtask
    task automatic wait_sig(input logic blank, input logic lvl);
        for (int n = 0; n < 1500; n++) begin
            @(posedge aclk);
            if ((blank ? disp_blank : lamp_zeroed) === lvl) return;
        end
        timeout();
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        check_val("disp_bright", 32'(pfp_pkg::BRIGHT_RST), 32'(disp_bright));
        check_val("chan_led", 32'h1, 32'(chan_led));
        check_val("volt_sp0", 32'h0, 32'(volt_sp[0]));
        stat_res(pfp_pkg::RES_COARSE);
        $display("test reset done");
        i_pfp_operator.turn(1'b1, 3);
        check_val("volt_sp0", 32'(3 * pfp_pkg::COARSE_STEP), 32'(volt_sp[0]));
        axi_rd(pfp_pkg::REG_SETPT, rd, rs);
        check_val("setpt", 32'(3 * pfp_pkg::COARSE_STEP), rd);
        i_pfp_operator.press(pfp_pkg::BTN_RES, 10);
        stat_res(pfp_pkg::RES_COARSE);
        i_pfp_operator.press(pfp_pkg::BTN_RES, 40);
        stat_res(pfp_pkg::RES_FINE);
        i_pfp_operator.turn(1'b1, 2);
        keep = 16'(3 * pfp_pkg::COARSE_STEP + 2 * pfp_pkg::FINE_STEP);
        check_val("volt_sp0", 32'(keep), 32'(volt_sp[0]));
        i_pfp_operator.press(pfp_pkg::BTN_RES, 40);
        stat_res(pfp_pkg::RES_PARK);
        i_pfp_operator.turn(1'b0, 4);
        check_val("volt_sp0", 32'(keep), 32'(volt_sp[0]));
        i_pfp_operator.press(pfp_pkg::BTN_RES, 40);
        stat_res(pfp_pkg::RES_COARSE);
        $display("test resolution done");
        i_pfp_operator.turn(1'b0, 5);
        check_val("volt_sp0", 32'h0, 32'(volt_sp[0]));
        i_pfp_operator.turn(1'b1, 1);
        check_val("volt_sp0", 32'(pfp_pkg::COARSE_STEP), 32'(volt_sp[0]));
        i_pfp_operator.turn(1'b1, 252);
        check_val("volt_sp0", 32'(pfp_pkg::LIM_75), 32'(volt_sp[0]));
        i_pfp_operator.turn(1'b0, 1);
        keep = pfp_pkg::LIM_75 - pfp_pkg::COARSE_STEP;
        check_val("volt_sp0", 32'(keep), 32'(volt_sp[0]));
        $display("test saturation done");
        i_pfp_operator.press(pfp_pkg::BTN_MAX, 40);
        axi_rd(pfp_pkg::REG_STAT, rd, rs);
        check_val("stat_edit", 32'h1, 32'(rd[6]));
        check_val("disp_value", 32'(pfp_pkg::LIM_75), 32'(disp_value));
        i_pfp_operator.turn(1'b1, 1);
        check_val("disp_value", 32'(pfp_pkg::LIM_100), 32'(disp_value));
        i_pfp_operator.turn(1'b1, 1);
        check_val("disp_value", 32'(pfp_pkg::LIM_150), 32'(disp_value));
        i_pfp_operator.press(pfp_pkg::BTN_MAX, 40);
        axi_rd(pfp_pkg::REG_STAT, rd, rs);
        check_val("stat_edit", 32'h0, 32'(rd[6]));
        i_pfp_operator.turn(1'b1, 260);
        check_val("volt_sp0", 32'(pfp_pkg::LIM_150), 32'(volt_sp[0]));
        @(posedge aclk);
        legacy_stage <= 1'b1;
        settle(3);
        check_val("volt_sp0", 32'(pfp_pkg::LIM_75), 32'(volt_sp[0]));
        i_pfp_operator.turn(1'b1, 1);
        check_val("volt_sp0", 32'(pfp_pkg::LIM_75), 32'(volt_sp[0]));
        @(posedge aclk);
        legacy_stage <= 1'b0;
        $display("test limit done");
        i_pfp_operator.press(pfp_pkg::BTN_LOOP, 40);
        check_val("lamp_closed", 32'h1, 32'(lamp_closed));
        check_val("loop_closed0", 32'h1, 32'(loop_closed[0]));
        i_pfp_operator.turn(1'b1, 80);
        check_val("pos_sp0", 32'(80 * pfp_pkg::COARSE_STEP), 32'(pos_sp[0]));
        check_val("volt_sp0", 32'(pfp_pkg::LIM_75), 32'(volt_sp[0]));
        i_pfp_operator.press(pfp_pkg::BTN_UNIT, 40);
        check_val("lamp_microns", 32'h1, 32'(lamp_microns));
        check_val("disp_value", 32'(80 * pfp_pkg::COARSE_STEP), 32'(disp_value));
        $display("test loop and unit done");
        axi_wr(pfp_pkg::REG_CTRL, 32'h2, rs);
        check_resp("ctrl_wr", pfp_pkg::RESP_OKAY, rs);
        settle(3);
        check_val("zeroing0", 32'h1, 32'(zeroing[0]));
        keep = disp_value;
        wait_sig(1'b0, !lamp_zeroed);
        settle(1);
        check_val("countdown", 32'h1, 32'(disp_value < keep));
        @(posedge aclk);
        zero_done <= 3'h1;
        @(posedge aclk);
        zero_done <= 3'h0;
        settle(3);
        check_val("zeroing0", 32'h0, 32'(zeroing[0]));
        check_val("lamp_zeroed", 32'h1, 32'(lamp_zeroed));
        settle(1100);
        check_val("lamp_zeroed", 32'h1, 32'(lamp_zeroed));
        $display("test zeroing done");
        keep = pos_sp[0];
        i_pfp_operator.hold_level(pfp_pkg::BTN_RES, 1'b1);
        i_pfp_operator.turn(1'b1, 2);
        i_pfp_operator.hold_level(pfp_pkg::BTN_RES, 1'b0);
        check_val("disp_bright", 32'(pfp_pkg::BRIGHT_RST + 4'h2), 32'(disp_bright));
        check_val("pos_sp0", 32'(keep), 32'(pos_sp[0]));
        stat_res(pfp_pkg::RES_COARSE);
        $display("test brightness done");
        axi_wr(pfp_pkg::REG_CTRL, 32'h1, rs);
        wait_sig(1'b1, 1'b1);
        axi_wr(pfp_pkg::REG_CTRL, 32'h0, rs);
        axi_rd(pfp_pkg::REG_CTRL, rd, rs);
        check_val("ctrl_rd", 32'h0, rd);
        axi_rd(8'h10, rd, rs);
        check_resp("unmapped_rd", pfp_pkg::RESP_DECERR, rs);
        axi_wr(pfp_pkg::REG_STAT, 32'h0, rs);
        check_resp("ro_wr", pfp_pkg::RESP_DECERR, rs);
        $display("test identify and bus done");
        i_pfp_operator.press(pfp_pkg::BTN_CHAN, 40);
        check_val("chan_led", 32'h2, 32'(chan_led));
        check_val("lamp_closed", 32'h0, 32'(lamp_closed));
        i_pfp_operator.turn(1'b1, 1);
        check_val("volt_sp1", 32'(pfp_pkg::COARSE_STEP), 32'(volt_sp[1]));
        check_val("volt_sp0", 32'(pfp_pkg::LIM_75), 32'(volt_sp[0]));
        $display("test channel done");
        stop_test();
    end
endmodule
